// ---- logic/trace_recorder.v ----
// Sampling trace recorder top
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "trace_recorder_map.vh"
module trace_recorder #(
	parameter [20:0] TICK_CYCLES = `TICK_CYCLES
)
(
	input wire i_mclk,
	input wire i_nrst,
	input wire [3:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [31:0] o_rdata,
	input wire [15:0] i_bits,
	input wire [15:0] i_word0,
	input wire [15:0] i_word1,
	input wire [15:0] i_word2,
	input wire i_take_sample_instruction,
	input wire i_stop_trigger_instruction,
	output reg o_sample_mode_flag,
	output reg o_trace_end_flag,
	output reg o_stop_trigger_flag,
	output reg o_sampling_active_flag
);
	//----------------------------------------
	// States
	//----------------------------------------
	localparam [1:0] S_IDLE = 2'd0;
	localparam [1:0] S_RUN = 2'd1;
	localparam [1:0] S_DELAY = 2'd2;
	localparam [1:0] S_DRAIN = 2'd3;

	//----------------------------------------
	// Functions
	//----------------------------------------
	function [9:0] wrap_inc;
		input [9:0] v;
		begin
			wrap_inc = (v == `STORE_LAST) ? 10'h000 : v + 10'h001;
		end
	endfunction

	function [9:0] oldest_rel;
		input [9:0] idx;
		input [9:0] base;
		input wrapped;
		reg [10:0] sum;
		begin
			sum = {1'b0, idx} + (wrapped ? {1'b0, base} : 11'h000);
			if (sum >= `STORE_DEPTH)
				oldest_rel = sum[9:0] - 10'h3e8;
			else
				oldest_rel = sum[9:0];
		end
	endfunction

	//----------------------------------------
	// Registers and nets
	//----------------------------------------
	reg [1:0] state_q;
	reg [15:0] trace_interval_word_q;
	reg [15:0] delay_q;
	reg [15:0] delay_cnt_q;
	reg [15:0] tick_cnt_q;
	reg [9:0] wr_ptr_q;
	reg [10:0] count_q;
	reg [9:0] rd_idx_q;
	reg [9:0] phys_q;
	reg overflow_q;
	reg [`SAMPLE_W-1:0] store [0:`STORE_DEPTH-1];
	reg [`SAMPLE_W-1:0] rd_word_q;
	reg [`SAMPLE_W-1:0] capture_q;
	reg capture_v_q;

	wire tick;
	wire fifo_ready;
	wire fifo_valid;
	wire [`SAMPLE_W-1:0] fifo_data;
	wire wr_ctl = i_wr && (i_addr == `REG_CONTROL);
	wire tool_start = wr_ctl && i_wdata[`CTL_START];
	wire tool_abort = wr_ctl && i_wdata[`CTL_STOP];
	wire tool_trig = wr_ctl && i_wdata[`CTL_TRIGGER];
	wire periodic = (trace_interval_word_q != 16'h0000);
	wire sampling = (state_q == S_RUN) || (state_q == S_DELAY);
	wire period_hit = tick && (tick_cnt_q >= trace_interval_word_q - 16'h0001);
	// Only the selected mode may sample
	wire sample_req = sampling && (periodic ? period_hit : i_take_sample_instruction);
	wire trig_in = tool_trig || i_stop_trigger_instruction;
	wire accept = sample_req && fifo_ready;
	wire drain_done = (state_q == S_DRAIN) && !fifo_valid && !capture_v_q;

	//----------------------------------------
	// Interval timer
	//----------------------------------------
	tick_divider #(
		.CYCLES(TICK_CYCLES)
	) u_tick (
		.i_mclk(i_mclk),
		.i_nrst(i_nrst),
		.i_run(sampling && periodic),
		.o_tick(tick)
	);

	always @(posedge i_mclk)
	begin
		if (!i_nrst || !sampling)
			tick_cnt_q <= 16'h0000;
		else if (period_hit)
			tick_cnt_q <= 16'h0000;
		else if (tick)
			tick_cnt_q <= tick_cnt_q + 16'h0001;
	end

	//----------------------------------------
	// Snapshot capture
	//----------------------------------------
	always @(posedge i_mclk)
	begin
		if (!i_nrst)
		begin
			capture_q <= {`SAMPLE_W{1'b0}};
			capture_v_q <= 1'b0;
		end
		else
		begin
			// A start drops a capture still in flight
			capture_v_q <= accept && !tool_start;
			if (accept)
				capture_q <= {i_word2, i_word1, i_word0, i_bits};
		end
	end

	//----------------------------------------
	// Snapshot FIFO
	//----------------------------------------
	sample_fifo #(
		.WIDTH(`SAMPLE_W),
		.DEPTH(`FIFO_DEPTH),
		.AW(`FIFO_AW)
	) u_fifo (
		.i_mclk(i_mclk),
		.i_nrst(i_nrst),
		.i_flush(tool_start),
		.i_valid(capture_v_q),
		.o_ready(fifo_ready),
		.i_data(capture_q),
		.o_valid(fifo_valid),
		.i_ready(1'b1),
		.o_data(fifo_data)
	);

	//----------------------------------------
	// Trace store
	//----------------------------------------
	always @(posedge i_mclk)
	begin
		// No reset: count and pointer say which words hold samples
		if (fifo_valid)
			store[wr_ptr_q] <= fifo_data;
		rd_word_q <= store[phys_q];
	end

	always @(posedge i_mclk)
	begin
		if (!i_nrst || tool_start)
		begin
			wr_ptr_q <= 10'h000;
			count_q <= 11'h000;
			overflow_q <= 1'b0;
		end
		else if (fifo_valid)
		begin
			wr_ptr_q <= wrap_inc(wr_ptr_q);
			if (count_q == `STORE_DEPTH)
				overflow_q <= 1'b1;
			else
				count_q <= count_q + 11'h001;
		end
	end

	//----------------------------------------
	// Sequence control
	//----------------------------------------
	always @(posedge i_mclk)
	begin
		if (!i_nrst)
		begin
			state_q <= S_IDLE;
			delay_cnt_q <= 16'h0000;
		end
		// Start wins over abort and triggers
		else if (tool_start)
		begin
			state_q <= S_RUN;
			delay_cnt_q <= 16'h0000;
		end
		else if (tool_abort)
			state_q <= S_IDLE;
		else
		begin
			case (state_q)
				S_RUN:
				begin
					if (trig_in)
					begin
						state_q <= (delay_q == 16'h0000) ? S_DRAIN : S_DELAY;
						delay_cnt_q <= delay_q;
					end
				end
				S_DELAY:
				begin
					// Triggers ignored here
					if (accept)
					begin
						delay_cnt_q <= delay_cnt_q - 16'h0001;
						if (delay_cnt_q == 16'h0001)
							state_q <= S_DRAIN;
					end
				end
				S_DRAIN:
				begin
					if (!fifo_valid && !capture_v_q)
						state_q <= S_IDLE;
				end
				default:
				begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	//----------------------------------------
	// Status flags
	//----------------------------------------
	always @(posedge i_mclk)
	begin
		if (!i_nrst)
		begin
			o_sample_mode_flag <= 1'b0;
			o_trace_end_flag <= 1'b0;
			o_stop_trigger_flag <= 1'b0;
			o_sampling_active_flag <= 1'b0;
		end
		else
		begin
			o_sample_mode_flag <= periodic;
			if (tool_start)
				o_trace_end_flag <= 1'b0;
			else if (drain_done)
				o_trace_end_flag <= 1'b1;
			else if (tool_abort && state_q != S_IDLE)
				o_trace_end_flag <= 1'b1;
			if (tool_start)
				o_stop_trigger_flag <= 1'b0;
			else if (state_q == S_RUN && trig_in)
				o_stop_trigger_flag <= 1'b1;
			if (tool_start)
				o_sampling_active_flag <= 1'b1;
			else if (tool_abort || drain_done)
				o_sampling_active_flag <= 1'b0;
		end
	end

	//----------------------------------------
	// Register port
	//----------------------------------------
	always @(posedge i_mclk)
	begin
		if (!i_nrst)
		begin
			trace_interval_word_q <= `INTERVAL_RESET;
			delay_q <= `DELAY_RESET;
			rd_idx_q <= 10'h000;
		end
		else if (i_wr)
		begin
			// Setup words locked while sampling runs
			if (i_addr == `REG_INTERVAL && !sampling)
			begin
				if (i_wdata[15:0] > `INTERVAL_MAX)
					trace_interval_word_q <= `INTERVAL_MAX;
				else
					trace_interval_word_q <= i_wdata[15:0];
			end
			else if (i_addr == `REG_DELAY && !sampling)
				delay_q <= i_wdata[15:0];
			else if (i_addr == `REG_READ_PTR)
				rd_idx_q <= (i_wdata[9:0] > `STORE_LAST) ? `STORE_LAST : i_wdata[9:0];
		end
	end

	//----------------------------------------
	// Read index mapping
	//----------------------------------------
	// Oldest sample sits at the write pointer once the store wrapped
	always @(posedge i_mclk)
	begin
		if (!i_nrst)
			phys_q <= 10'h000;
		else
			phys_q <= oldest_rel(rd_idx_q, wr_ptr_q, overflow_q);
	end

	//----------------------------------------
	// Register reads
	//----------------------------------------
	always @(posedge i_mclk)
	begin
		if (!i_nrst)
			o_rdata <= 32'h00000000;
		else if (i_rd)
		begin
			if (i_addr == `REG_INTERVAL)
				o_rdata <= {16'h0000, trace_interval_word_q};
			else if (i_addr == `REG_DELAY)
				o_rdata <= {16'h0000, delay_q};
			else if (i_addr == `REG_STATUS)
				o_rdata <= {27'h0000000, overflow_q, o_sampling_active_flag,
					o_stop_trigger_flag, o_trace_end_flag, o_sample_mode_flag};
			else if (i_addr == `REG_COUNT)
				o_rdata <= {21'h000000, count_q};
			else if (i_addr == `REG_READ_PTR)
				o_rdata <= {22'h000000, rd_idx_q};
			else if (i_addr == `REG_READ_BITS)
				o_rdata <= {16'h0000, rd_word_q[15:0]};
			else if (i_addr == `REG_READ_W0)
				o_rdata <= {16'h0000, rd_word_q[31:16]};
			else if (i_addr == `REG_READ_W1)
				o_rdata <= {16'h0000, rd_word_q[47:32]};
			else if (i_addr == `REG_READ_W2)
				o_rdata <= {16'h0000, rd_word_q[63:48]};
			else
				o_rdata <= 32'h00000000;
		end
		else
			o_rdata <= 32'h00000000;
	end
endmodule
`default_nettype wire

// ---- logic/trace_recorder_map.vh ----
// Constants of the sampling trace recorder
//----------------------------------------
// What this block does
//----------------------------------------
`ifndef TRACE_RECORDER_MAP_VH
`define TRACE_RECORDER_MAP_VH
`define REG_INTERVAL 4'h0
`define REG_DELAY 4'h1
`define REG_CONTROL 4'h2
`define REG_STATUS 4'h3
`define REG_COUNT 4'h4
`define REG_READ_PTR 4'h5
`define REG_READ_BITS 4'h6
`define REG_READ_W0 4'h7
`define REG_READ_W1 4'h8
`define REG_READ_W2 4'h9
`define CTL_START 0
`define CTL_STOP 1
`define CTL_TRIGGER 2
`define ST_MODE 0
`define ST_END 1
`define ST_TRIG 2
`define ST_ACTIVE 3
`define ST_OVERFLOW 4
`define INTERVAL_RESET 16'h0000
`define DELAY_RESET 16'h0000
`define INTERVAL_MAX 16'h0bb8
`define STORE_DEPTH 1000
`define STORE_LAST 10'h3e7
`define TICK_MS 10
`define CLK_MHZ 125
`define TICK_CYCLES 21'd1250000
`define SAMPLE_W 64
`define FIFO_DEPTH 32
`define FIFO_AW 5
`endif

// ---- logic/tick_divider.v ----
// Divider giving a one-cycle pulse every tick period
`timescale 1ns/100ps
`default_nettype none
module tick_divider #(
	parameter [20:0] CYCLES = 21'd1250000
)
(
	input wire i_mclk,
	input wire i_nrst,
	input wire i_run,
	output reg o_tick
);
	reg [20:0] cnt_q;
	always @(posedge i_mclk)
	begin
		if (!i_nrst || !i_run)
		begin
			cnt_q <= 21'd0;
			o_tick <= 1'b0;
		end
		else if (cnt_q == CYCLES - 21'd1)
		begin
			cnt_q <= 21'd0;
			o_tick <= 1'b1;
		end
		else
		begin
			cnt_q <= cnt_q + 21'd1;
			o_tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ---- logic/sample_fifo.v ----
// FIFO between the sample capture and the trace store
`timescale 1ns/100ps
`default_nettype none
module sample_fifo #(
	parameter WIDTH = 64,
	parameter DEPTH = 32,
	parameter AW = 5
)
(
	input wire i_mclk,
	input wire i_nrst,
	input wire i_flush,
	input wire i_valid,
	output wire o_ready,
	input wire [WIDTH-1:0] i_data,
	output wire o_valid,
	input wire i_ready,
	output wire [WIDTH-1:0] o_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0] wr_q;
	reg [AW:0] rd_q;
	wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	wire empty = (wr_q == rd_q);
	assign o_ready = !full;
	assign o_valid = !empty;
	assign o_data = mem[rd_q[AW-1:0]];
	always @(posedge i_mclk)
	begin
		if (i_valid && !full)
			mem[wr_q[AW-1:0]] <= i_data;
	end
	always @(posedge i_mclk)
	begin
		if (!i_nrst || i_flush)
		begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (i_valid && !full)
				wr_q <= wr_q + 1'b1;
			if (i_ready && !empty)
				rd_q <= rd_q + 1'b1;
		end
	end
endmodule
`default_nettype wire

// ---- bench/trace_recorder_sva.sv ----
// Port assertions for the trace recorder
`timescale 1ns/100ps
`default_nettype none
`include "trace_recorder_map.vh"
module trace_recorder_sva (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic [3:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic i_stop_trigger_instruction,
	input wire logic o_sample_mode_flag,
	input wire logic o_trace_end_flag,
	input wire logic o_stop_trigger_flag,
	input wire logic o_sampling_active_flag
);
//----------------------------------------
// Properties
//----------------------------------------
default clocking cb @(posedge i_mclk);
endclocking
default disable iff (!i_nrst);
wire logic ctl;
wire logic ivw;
assign ctl = i_wr && i_addr == `REG_CONTROL;
assign ivw = i_wr && i_addr == `REG_INTERVAL && !o_sampling_active_flag;
chk_start_flags: assert property (ctl && i_wdata[`CTL_START] |=> o_sampling_active_flag
	&& !o_trace_end_flag && !o_stop_trigger_flag) else $error("start flags wrong");
chk_trig_accept: assert property (o_sampling_active_flag && !o_stop_trigger_flag && !i_wr
	&& i_stop_trigger_instruction |=> o_stop_trigger_flag) else $error("trigger not taken");
chk_trig_hold: assert property ($fell(o_stop_trigger_flag) |-> $past(ctl))
	else $error("trigger flag dropped");
chk_end_idle: assert property (o_trace_end_flag |-> !o_sampling_active_flag)
	else $error("end while active");
chk_rdata_zero: assert property (!i_rd |=> o_rdata == 32'h0) else $error("stray read data");
chk_abort_ends: assert property (ctl && i_wdata[2:0] == 3'h2 && o_sampling_active_flag
	|=> o_trace_end_flag && !o_sampling_active_flag) else $error("abort did not stop");
chk_mode_instr: assert property (ivw && i_wdata[15:0] == 16'h0 |-> ##[1:2] !o_sample_mode_flag)
	else $error("mode not instruction");
chk_mode_period: assert property (ivw && i_wdata[15:0] != 16'h0 |-> ##[1:2] o_sample_mode_flag)
	else $error("mode not periodic");
cover property (o_stop_trigger_flag && o_sampling_active_flag);
cover property ($rose(o_trace_end_flag));
cover property (o_sample_mode_flag && o_sampling_active_flag);
endmodule
`default_nettype wire

// ---- bench/scan_model.sv ----
// Program scan model issuing sample and stop instructions
`timescale 1ns/100ps
`default_nettype none
module scan_model (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_go,
	input wire logic i_spaced,
	input wire logic i_trig,
	input wire logic [10:0] i_n,
	output logic o_sample,
	output logic o_stop,
	output logic o_busy,
	output logic [15:0] o_bits,
	output logic [15:0] o_w0,
	output logic [15:0] o_w1,
	output logic [15:0] o_w2
);
//----------------------------------------
// Instruction pulses and live data
//----------------------------------------
logic [10:0] left_q;
logic [1:0] gap_q;
logic [15:0] cur_q;
logic [15:0] nxt_q;
assign o_busy = left_q != 11'h0 || o_sample;
assign o_bits = cur_q;
assign o_w0 = cur_q + 16'h1;
assign o_w1 = ~cur_q;
assign o_w2 = cur_q ^ 16'h5a5a;
always @(posedge i_mclk)
begin
	o_sample <= 1'b0;
	o_stop <= i_trig && i_nrst;
	if (!i_nrst)
	begin
		left_q <= 11'h0;
		gap_q <= 2'h0;
		cur_q <= 16'h0;
		nxt_q <= 16'h0;
	end
	else if (i_go)
		left_q <= i_n;
	else if (left_q != 11'h0 && gap_q == 2'h0)
	begin
		o_sample <= 1'b1;
		cur_q <= nxt_q;
		nxt_q <= nxt_q + 16'h1;
		left_q <= left_q - 11'h1;
		gap_q <= i_spaced ? 2'h3 : 2'h0;
	end
	else if (gap_q != 2'h0)
		gap_q <= gap_q - 2'h1;
end
endmodule
`default_nettype wire

// ---- bench/trace_recorder_tb.sv ----
// Self-checking testbench of the trace recorder
`timescale 1ns/100ps
`default_nettype none
`include "trace_recorder_map.vh"
module trace_recorder_tb;
//----------------------------------------
// Stimulus and checks
//----------------------------------------
logic i_mclk = 1'b0;
logic i_nrst = 1'b0;
logic i_wr = 1'b0;
logic i_rd = 1'b0;
logic p_go = 1'b0;
logic p_sp = 1'b0;
logic p_trig = 1'b0;
logic [3:0] i_addr = 4'h0;
logic [31:0] i_wdata = 32'h0;
logic [31:0] v;
logic [10:0] p_n = 11'h0;
wire [31:0] o_rdata;
wire [15:0] d_b, d_0, d_1, d_2;
wire smp, stp, busy, f_mode, f_end, f_trig, f_act;
int fail_count = 0;
int cmp_count = 0;
int k;
int j;
initial
begin
	forever #4 i_mclk = ~i_mclk;
end
trace_recorder #(.TICK_CYCLES(21'd10)) uut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_bits(d_b), .i_word0(d_0),
	.i_word1(d_1), .i_word2(d_2), .i_take_sample_instruction(smp), .i_stop_trigger_instruction(stp),
	.o_sample_mode_flag(f_mode), .o_trace_end_flag(f_end), .o_stop_trigger_flag(f_trig),
	.o_sampling_active_flag(f_act));
scan_model scan (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_go(p_go), .i_spaced(p_sp), .i_trig(p_trig),
	.i_n(p_n), .o_sample(smp), .o_stop(stp), .o_busy(busy), .o_bits(d_b), .o_w0(d_0),
	.o_w1(d_1), .o_w2(d_2));
task final_report;
	if (fail_count == 0 && cmp_count > 0)
		$display("Testbench passed");
	else
		$display("Testbench failed");
	$finish;
endtask
task c32(input logic [31:0] g, input logic [31:0] e);
	cmp_count++;
	if (g !== e)
	begin
		fail_count++;
		$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
	end
endtask
task cb(input logic g, input logic e);
	c32({31'h0, g}, {31'h0, e});
endtask
task wr(input logic [3:0] a, input logic [31:0] d);
	@(posedge i_mclk);
	i_addr <= a;
	i_wdata <= d;
	i_wr <= 1'b1;
	@(posedge i_mclk);
	i_wr <= 1'b0;
endtask
task rd(input logic [3:0] a);
	@(posedge i_mclk);
	i_addr <= a;
	i_rd <= 1'b1;
	@(posedge i_mclk);
	i_rd <= 1'b0;
	#1 v = o_rdata;
endtask
task burst(input logic [10:0] n, input logic sp);
	@(posedge i_mclk);
	p_n <= n;
	p_sp <= sp;
	p_go <= 1'b1;
	@(posedge i_mclk);
	p_go <= 1'b0;
	@(negedge i_mclk);
	for (k = 0; k < 2000 && busy !== 1'b0; k++)
		@(negedge i_mclk);
	repeat (4) @(posedge i_mclk);
endtask
task trig_instr;
	@(posedge i_mclk);
	p_trig <= 1'b1;
	@(posedge i_mclk);
	p_trig <= 1'b0;
endtask
task wait_end;
	for (k = 0; k < 4000 && f_end !== 1'b1; k++)
		@(negedge i_mclk);
	cb(f_end, 1'b1);
endtask
task chks(input logic [9:0] i, input logic [15:0] s);
	wr(`REG_READ_PTR, {22'h0, i});
	repeat (3) @(posedge i_mclk);
	rd(`REG_READ_BITS);
	c32(v, {16'h0, s});
	rd(`REG_READ_W0);
	c32(v, {16'h0, s + 16'h1});
	rd(`REG_READ_W1);
	c32(v, {16'h0, ~s});
	rd(`REG_READ_W2);
	c32(v, {16'h0, s ^ 16'h5a5a});
endtask
initial
begin
	repeat (5) @(posedge i_mclk);
	i_nrst <= 1'b1;
	for (j = 0; j < 4; j++)
	begin
		rd(j == 3 ? 4'hf : j[3:0] + (j == 2 ? 4'h1 : 4'h0));
		c32(v, 32'h0);
	end
	wr(`REG_DELAY, 32'h2);
	wr(`REG_CONTROL, 32'h1);
	rd(`REG_STATUS);
	c32(v, 32'h8);
	burst(11'h5, 1'b0);
	burst(11'h3, 1'b1);
	rd(`REG_COUNT);
	c32(v, 32'h8);
	trig_instr;
	trig_instr;
	cb(f_trig, 1'b1);
	burst(11'h2, 1'b1);
	wait_end;
	rd(`REG_COUNT);
	c32(v, 32'ha);
	rd(`REG_STATUS);
	c32(v, 32'h6);
	for (j = 0; j < 10; j++)
		chks(j[9:0], j[15:0]);
	wr(`REG_DELAY, 32'h0);
	wr(`REG_CONTROL, 32'h1);
	rd(`REG_STATUS);
	c32(v, 32'h8);
	burst(11'h3ed, 1'b0);
	wr(`REG_CONTROL, 32'h4);
	wait_end;
	rd(`REG_COUNT);
	c32(v, 32'h3e8);
	rd(`REG_STATUS);
	c32(v, 32'h16);
	chks(10'h0, 16'h000f);
	chks(10'h3e7, 16'h03f6);
	wr(`REG_READ_PTR, 32'h3f0);
	rd(`REG_READ_PTR);
	c32(v, 32'h3e7);
	wr(`REG_INTERVAL, 32'hfa0);
	rd(`REG_INTERVAL);
	c32(v, 32'hbb8);
	wr(`REG_INTERVAL, 32'h3);
	cb(f_mode, 1'b1);
	wr(`REG_CONTROL, 32'h1);
	wr(`REG_INTERVAL, 32'h5);
	rd(`REG_INTERVAL);
	c32(v, 32'h3);
	burst(11'h4, 1'b1);
	repeat (200) @(posedge i_mclk);
	wr(`REG_CONTROL, 32'h4);
	wait_end;
	rd(`REG_STATUS);
	c32(v, 32'h7);
	rd(`REG_COUNT);
	cb(v >= 32'h4 && v <= 32'h9, 1'b1);
	chks(v[9:0] - 10'h1, 16'h03fa);
	wr(`REG_CONTROL, 32'h1);
	wr(`REG_CONTROL, 32'h2);
	rd(`REG_STATUS);
	c32(v, 32'h3);
	final_report;
end
initial
begin
	repeat (20000) @(posedge i_mclk);
	fail_count++;
	final_report;
end
endmodule
bind trace_recorder trace_recorder_sva chk (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_stop_trigger_instruction(i_stop_trigger_instruction),
	.o_sample_mode_flag(o_sample_mode_flag), .o_trace_end_flag(o_trace_end_flag),
	.o_stop_trigger_flag(o_stop_trigger_flag), .o_sampling_active_flag(o_sampling_active_flag));
`default_nettype wire
